// *** common/hcef_pkg.sv ***
// Functional notes
// - Flags live; pin needs mask and enable.
// - Flag clears only on written one.
// - Driver writes FFh, which clears flags 7 to 0 only; bits 9 and 8 stay set.
// - Read code 24, write code A4.
// - Bit 9 on dual-role event.
// - Bit 8 on async-list done event.
// - Bit 7 on periodic-list done event.
// - Bit 6 when clock restored after suspend.
// - Bit 5 once controller is suspended.
// - No start-of-frame needed while suspended.
// - Bit 4 on operational event.
// - Bit 3 on transfer end.
// - Bits 2 and 1 on isochronous buffer done.
// - Bit 0 on start-of-frame state.
// - All mask bits zero after power-on.
package hcef_pkg;
  localparam int FLAG_W = 10;
  localparam int DATA_W = 16;
  localparam logic [7:0] CMD_FLAGS_RD = 8'h24;
  localparam logic [7:0] CMD_FLAGS_WR = 8'hA4;
  localparam logic [7:0] CMD_MASK_RD = 8'h25;
  localparam logic [7:0] CMD_MASK_WR = 8'hA5;
  localparam logic [7:0] CLEAR_ALL = 8'hFF;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 10'h000;
  localparam logic [FLAG_W-1:0] MASK_RST = 10'h000;
  localparam int BIT_SOF = 0;
  localparam int BIT_ISO0 = 1;
  localparam int BIT_ISO1 = 2;
  localparam int BIT_XFER_END = 3;
  localparam int BIT_OPER = 4;
  localparam int BIT_SUSP = 5;
  localparam int BIT_CLK_RDY = 6;
  localparam int BIT_PERIODIC = 7;
  localparam int BIT_ASYNC = 8;
  localparam int BIT_DUAL_ROLE = 9;

  typedef enum logic [2:0] {
    HCEF_IDLE = 3'b001,
    HCEF_WAIT = 3'b010,
    HCEF_DONE = 3'b100
  } hcef_host_st_t;
endpackage : hcef_pkg

// *** common/hcef_if.sv ***
`timescale 1ns/1ns
interface hcef_if;
  import hcef_pkg::*;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  logic rd_valid;
  logic host_irq_pin;
  modport dev (input cmd_valid, input cmd_code, input wr_data,
    output rd_data, output rd_valid, output host_irq_pin);
  modport cpu (output cmd_valid, output cmd_code, output wr_data,
    input rd_data, input rd_valid, input host_irq_pin);
endinterface : hcef_if

// *** rtl/hcef_device.sv ***
`timescale 1ns/1ns
module hcef_device
  import hcef_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  hcef_if.dev bus,
  input wire logic pin_enable,
  input wire logic dual_role_event,
  input wire logic async_list_event,
  input wire logic periodic_list_event,
  input wire logic clock_restored_event,
  input wire logic suspended_event,
  input wire logic operational_event,
  input wire logic transfer_end_event,
  input wire logic iso_buffer1_done,
  input wire logic iso_buffer0_done,
  input wire logic sof_event,
  output logic sof_allowed
);
  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] mask;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic irq;
    logic suspended;
  } hcef_dev_st_t;

  hcef_dev_st_t s_q;
  hcef_dev_st_t s_d;
  logic [FLAG_W-1:0] ev;
  logic [FLAG_W-1:0] clr;

  function automatic logic [DATA_W-1:0] widen_flags(input logic [FLAG_W-1:0] v);
    widen_flags = {{(DATA_W-FLAG_W){1'b0}}, v};
  endfunction : widen_flags

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ev = '0;
    ev[BIT_DUAL_ROLE] = dual_role_event;
    ev[BIT_ASYNC] = async_list_event;
    ev[BIT_PERIODIC] = periodic_list_event;
    ev[BIT_CLK_RDY] = clock_restored_event;
    ev[BIT_SUSP] = suspended_event;
    ev[BIT_OPER] = operational_event;
    ev[BIT_XFER_END] = transfer_end_event;
    ev[BIT_ISO1] = iso_buffer1_done;
    ev[BIT_ISO0] = iso_buffer0_done;
    ev[BIT_SOF] = sof_event;
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    clr = '0;
    if (bus.cmd_valid) begin
      case (bus.cmd_code)
        CMD_FLAGS_RD: begin
          s_d.rd_data = widen_flags(s_q.flags);
          s_d.rd_valid = 1'b1;
        end
        CMD_FLAGS_WR: begin
          clr = bus.wr_data[FLAG_W-1:0];
        end
        CMD_MASK_RD: begin
          s_d.rd_data = widen_flags(s_q.mask);
          s_d.rd_valid = 1'b1;
        end
        CMD_MASK_WR: begin
          s_d.mask = bus.wr_data[FLAG_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // A new event outweighs a clear in the same cycle so it cannot be lost.
    s_d.flags = (s_q.flags & ~clr) | ev;
    s_d.irq = pin_enable & (|(s_d.flags & s_d.mask));
    // Suspension ends when the clock comes back.
    if (suspended_event) begin
      s_d.suspended = 1'b1;
    end else if (clock_restored_event) begin
      s_d.suspended = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q.flags <= FLAGS_RST;
      s_q.mask <= MASK_RST;
      s_q.rd_data <= '0;
      s_q.rd_valid <= 1'b0;
      s_q.irq <= 1'b0;
      s_q.suspended <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus.rd_data = s_q.rd_data;
  assign bus.rd_valid = s_q.rd_valid;
  assign bus.host_irq_pin = s_q.irq;
  assign sof_allowed = ~s_q.suspended;
endmodule : hcef_device

// *** rtl/hcef_cpu.sv ***
`timescale 1ns/1ns
module hcef_cpu
  import hcef_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  hcef_if.cpu bus,
  input wire logic req_valid,
  input wire logic [7:0] req_code,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic clear_all,
  output logic req_ready,
  output logic [DATA_W-1:0] resp_data,
  output logic resp_valid,
  output logic irq_seen
);
  typedef struct packed {
    hcef_host_st_t st;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] resp_data;
    logic resp_valid;
    logic irq_s1;
    logic irq_s2;
  } hcef_cpu_st_t;

  hcef_cpu_st_t s_q;
  hcef_cpu_st_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.cmd_valid = 1'b0;
    s_d.resp_valid = 1'b0;
    // The irq pin is treated as foreign and synchronised twice.
    s_d.irq_s1 = bus.host_irq_pin;
    s_d.irq_s2 = s_q.irq_s1;
    case (s_q.st)
      HCEF_IDLE: begin
        if (clear_all) begin
          s_d.cmd_valid = 1'b1;
          s_d.cmd_code = CMD_FLAGS_WR;
          s_d.wr_data = {{(DATA_W-8){1'b0}}, CLEAR_ALL};
          s_d.st = HCEF_DONE;
        end else if (req_valid) begin
          s_d.cmd_valid = 1'b1;
          s_d.cmd_code = req_code;
          s_d.wr_data = req_data;
          s_d.st = req_code[7] ? HCEF_DONE : HCEF_WAIT;
        end
      end
      HCEF_WAIT: begin
        if (bus.rd_valid) begin
          s_d.resp_data = bus.rd_data;
          s_d.resp_valid = 1'b1;
          s_d.st = HCEF_IDLE;
        end else if (!s_q.cmd_valid) begin
          // A code the device does not know gets no answer, so give up once its slot has passed.
          s_d.st = HCEF_IDLE;
        end
      end
      HCEF_DONE: begin
        s_d.st = HCEF_IDLE;
      end
      default: begin
        s_d.st = HCEF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q.st <= HCEF_IDLE;
      s_q.cmd_valid <= 1'b0;
      s_q.cmd_code <= 8'h00;
      s_q.wr_data <= '0;
      s_q.resp_data <= '0;
      s_q.resp_valid <= 1'b0;
      s_q.irq_s1 <= 1'b0;
      s_q.irq_s2 <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus.cmd_valid = s_q.cmd_valid;
  assign bus.cmd_code = s_q.cmd_code;
  assign bus.wr_data = s_q.wr_data;
  assign req_ready = (s_q.st == HCEF_IDLE) & ~clear_all;
  assign resp_data = s_q.resp_data;
  assign resp_valid = s_q.resp_valid;
  assign irq_seen = s_q.irq_s2;
endmodule : hcef_cpu

// *** test/hcef_sva.sv ***
`timescale 1ns/1ns
module hcef_sva
  import hcef_pkg::*;
(
  input logic mclk,
  input logic sys_rst,
  input logic cmd_valid,
  input logic [7:0] cmd_code,
  input logic [DATA_W-1:0] rd_data,
  input logic rd_valid,
  input logic host_irq_pin
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  AST_FLAG_RD: assert property (cmd_valid && cmd_code == CMD_FLAGS_RD |=> rd_valid)
    else $error("no flag reply");
  AST_MASK_RD: assert property (cmd_valid && cmd_code == CMD_MASK_RD |=> rd_valid)
    else $error("no mask reply");
  AST_WR_QUIET: assert property (cmd_valid && cmd_code[7] |=> !rd_valid)
    else $error("write replied");
  AST_RD_CAUSE: assert property (rd_valid |-> $past(cmd_valid) && !$past(cmd_code[7]))
    else $error("stray reply");
  AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
    else $error("long strobe");
  AST_HI_ZERO: assert property (rd_valid |-> rd_data[15:10] == 6'h00)
    else $error("high bits set");
  AST_IRQ_RST: assert property ($past(sys_rst) |-> !host_irq_pin)
    else $error("irq after reset");
  // Either write code may drop the pin, since a mask write gates it as a flag write does.
  AST_IRQ_FALL: assert property ($fell(host_irq_pin) |-> $past(cmd_valid) && $past(cmd_code[7]))
    else $error("irq fell alone");
  cover property (cmd_valid && cmd_code == CMD_FLAGS_WR);
  cover property ($rose(host_irq_pin));
  cover property ($fell(host_irq_pin));
endmodule : hcef_sva

// *** test/host_cpu_event_flags_tb_top.sv ***
`timescale 1ns/1ns
module host_cpu_event_flags_tb_top
  import hcef_pkg::*;
;
  logic mclk = 1'b0, sys_rst = 1'b1, pin_enable = 1'b0, clear_all = 1'b0, req_valid = 1'b0;
  logic [9:0] ev = 10'h000;
  logic [7:0] req_code = 8'h00;
  logic [15:0] req_data = 16'h0000, resp_data, rd, m;
  logic req_ready, resp_valid, irq_seen, sof_allowed;
  int error_cnt = 0, n_compared = 0;
  hcef_if bi ();
  always #25 mclk = ~mclk;
  hcef_device u_hcef_device (.mclk, .sys_rst, .bus(bi.dev), .pin_enable, .sof_allowed,
    .dual_role_event(ev[9]), .async_list_event(ev[8]), .periodic_list_event(ev[7]),
    .clock_restored_event(ev[6]), .suspended_event(ev[5]), .operational_event(ev[4]),
    .transfer_end_event(ev[3]), .iso_buffer1_done(ev[2]), .iso_buffer0_done(ev[1]),
    .sof_event(ev[0]));
  hcef_cpu u_hcef_cpu (.mclk, .sys_rst, .bus(bi.cpu), .req_valid, .req_code, .req_data,
    .clear_all, .req_ready, .resp_data, .resp_valid, .irq_seen);
  hcef_sva u_hcef_sva (.mclk, .sys_rst, .cmd_valid(bi.cmd_valid), .cmd_code(bi.cmd_code),
    .rd_data(bi.rd_data), .rd_valid(bi.rd_valid), .host_irq_pin(bi.host_irq_pin));
  task automatic chk(input string w, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // Five idle cycles outlast the slowest reply, so no request meets a busy host side.
  task automatic acc(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
    rd = 16'hXXXX;
    req_valid = 1'b1;
    req_code = c;
    req_data = d;
    cyc(1);
    req_valid = 1'b0;
    chk("busy", 16'(req_ready), 16'h0000);
    repeat (5) begin
      if (resp_valid === 1'b1) rd = resp_data;
      cyc(1);
    end
    chk("ready", 16'(req_ready), 16'h0001);
    if (!c[7]) chk("read", rd, e);
  endtask : acc
  task automatic wrap_up();
    $display("compared %0d wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
  initial begin : main
    cyc(20);
    sys_rst = 1'b0;
    acc(CMD_MASK_RD, 16'h0000, 16'h0000);
    for (int k = 0; k < FLAG_W; k++) begin
      m = 16'h0001 << k;
      ev = m[9:0];
      cyc(1);
      ev = 10'h000;
      if (k == 5) chk("sof", 16'(sof_allowed), 16'h0000);
      if (k == 6) chk("sof", 16'(sof_allowed), 16'h0001);
      acc(CMD_FLAGS_WR, 16'h03FF ^ m, 16'h0000);
      acc(CMD_FLAGS_RD, 16'h0000, m);
      acc(CMD_FLAGS_WR, m, 16'h0000);
      acc(CMD_FLAGS_RD, 16'h0000, 16'h0000);
    end
    // The event reaches the device in the very cycle in which the clear of its bit lands.
    req_valid = 1'b1;
    req_code = CMD_FLAGS_WR;
    req_data = 16'h0008;
    cyc(1);
    req_valid = 1'b0;
    ev = 10'h008;
    cyc(1);
    ev = 10'h000;
    cyc(3);
    acc(8'hA6, 16'h03FF, 16'h0000);
    acc(8'h26, 16'h0000, 16'hXXXX);
    acc(CMD_FLAGS_RD, 16'h0000, 16'h0008);
    acc(CMD_FLAGS_WR, 16'h0008, 16'h0000);
    $display("flag test done");
    acc(CMD_MASK_WR, 16'h0201, 16'h0000);
    ev = 10'h201;
    cyc(2);
    chk("pin", 16'(bi.host_irq_pin), 16'h0000);
    pin_enable = 1'b1;
    cyc(4);
    chk("seen", 16'(irq_seen), 16'h0001);
    ev = 10'h000;
    clear_all = 1'b1;
    cyc(1);
    clear_all = 1'b0;
    cyc(4);
    acc(CMD_FLAGS_RD, 16'h0000, 16'h0200);
    acc(CMD_FLAGS_WR, 16'h0200, 16'h0000);
    chk("pin", 16'(bi.host_irq_pin), 16'h0000);
    $display("irq test done");
    acc(CMD_MASK_WR, 16'h03FF, 16'h0000);
    ev = 10'h010;
    cyc(1);
    ev = 10'h000;
    chk("pin", 16'(bi.host_irq_pin), 16'h0001);
    sys_rst = 1'b1;
    cyc(3);
    sys_rst = 1'b0;
    chk("pin", 16'(bi.host_irq_pin), 16'h0000);
    chk("sof", 16'(sof_allowed), 16'h0001);
    acc(CMD_MASK_RD, 16'h0000, 16'h0000);
    acc(CMD_FLAGS_RD, 16'h0000, 16'h0000);
    ev = 10'h010;
    cyc(1);
    ev = 10'h000;
    cyc(3);
    chk("seen", 16'(irq_seen), 16'h0000);
    acc(CMD_FLAGS_RD, 16'h0000, 16'h0010);
    $display("reset test done");
    wrap_up();
  end
endmodule : host_cpu_event_flags_tb_top
